/* File: rtl/sccg_pkg.sv */
// sccg_pkg: offsets, fields, reset values and helpers of the
// system clock generation block.
// assumes core_clk stands for the fastest internal rate (2x csb).
`default_nettype none
package sccg_pkg;
    // register byte offsets
    localparam logic [7:0] REG_RCW    = 8'h00;
    localparam logic [7:0] REG_OCC    = 8'h04;
    localparam logic [7:0] REG_LBC    = 8'h08;
    localparam logic [7:0] REG_SCC    = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // counts and widths
    localparam int NUM_PCI_OUT = 5;
    localparam int NUM_UNITS   = 9;
    localparam int NUM_RATIO   = 6;
    localparam int RCW_W       = 10;
    // reset config word fields
    localparam int RCW_SYSTEM_PLL_MULTIPLIER_LO  = 0;
    localparam int RCW_CORE_LO  = 4;
    localparam int RCW_MEMORY_CLOCK_MODE    = 8;
    localparam int RCW_LOCAL_BUS_CLOCK_MODE   = 9;
    // status fields
    localparam int ST_RATIO_LO  = 0;
    localparam int ST_RSVD      = 8;
    localparam int ST_HOST      = 9;
    localparam int ST_DIV       = 10;
    localparam int ST_SYNC_SEEN = 11;
    // unit clock modes
    typedef enum logic [1:0] {
        MODE_OFF, MODE_FULL, MODE_HALF, MODE_THIRD
    } sccg_mode_t;
    // local bus divide codes
    localparam logic [1:0] LBDIV_2 = 2'h0;
    localparam logic [1:0] LBDIV_4 = 2'h1;
    // reset values and multiplier codes
    localparam logic [NUM_PCI_OUT-1:0] OCC_RST = 5'h00;
    localparam logic [1:0]  LBC_RST = 2'h0;
    localparam logic [14:0] SCC_RST = 15'h7FFF;
    localparam logic [3:0]  SYSTEM_PLL_MULTIPLIER_X16  = 4'h0;
    localparam logic [3:0]  SYSTEM_PLL_MULTIPLIER_RSVD = 4'h1;

    // byte-lane merge for a register write
    function automatic logic [31:0] sccg_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    // multiplier code to factor; reserved reads as zero
    function automatic logic [4:0] sccg_mult(input logic [3:0] code);
        logic [4:0] f;
        f = {1'b0, code};
        if (code == SYSTEM_PLL_MULTIPLIER_X16)
            f = 5'h10;
        else if (code == SYSTEM_PLL_MULTIPLIER_RSVD)
            f = 5'h00;
        return f;
    endfunction
endpackage
`default_nettype wire

/* File: rtl/sccg_ratio.sv */
// sccg_ratio: one unit clock enable at full, half or third of base.
// assumes base_en is a one-cycle pulse train from the csb divider.
`timescale 1ns/1ps
`default_nettype none
module sccg_ratio
    import sccg_pkg::*;
#(
    parameter sccg_mode_t RST_MODE = MODE_THIRD
)
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // rate control
    input  wire logic       base_en,
    input  wire sccg_mode_t mode_in,
    // unit enable
    output var  logic       unit_en
);
    sccg_mode_t mode_r;
    logic [1:0] cnt_r;
    logic       unit_en_r;
    wire  [1:0] last_w = (mode_r == MODE_THIRD) ? 2'h2 :
                         (mode_r == MODE_HALF)  ? 2'h1 : 2'h0;
    wire        wrap_w = base_en && (cnt_r == last_w);

    // new mode only taken at a period end: no short pulse
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mode_r <= RST_MODE;
            cnt_r  <= 2'h0;
        end
        else if (wrap_w)
        begin
            mode_r <= mode_in;
            cnt_r  <= 2'h0;
        end
        else if (base_en)
            cnt_r <= cnt_r + 2'h1;
    end

    // one pulse at the start of each period
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            unit_en_r <= 1'b0;
        else
            unit_en_r <= base_en && cnt_r == 2'h0 && mode_r != MODE_OFF;
    end
    assign unit_en = unit_en_r;

    AST_MODE_AT_EDGE: assert property (@(posedge core_clk)
        disable iff (sys_rst) !$stable(mode_r) |-> cnt_r == 2'h0)
        else $error("unit mode changed inside a period");
    AST_OFF_SILENT: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        $past(mode_r) == MODE_OFF |-> !unit_en_r)
        else $error("unit enable while clock off");
    AST_THIRD_GAP: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        unit_en_r && mode_r == MODE_THIRD |=> !unit_en_r [*2])
        else $error("third-rate pulses too close");
endmodule
`default_nettype wire

/* File: rtl/sccg_top.sv */
// sccg_top: clock selection, dividers, pin clocks and unit clock
// enables, with registers on a classic Wishbone slave.
// assumes pin inputs are synchronous to core_clk and that core_clk
// stands for twice the system bus rate.
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sccg_top
    import sccg_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    // wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output var  logic [31:0]            wb_dat_o,
    output var  logic                   wb_ack_o,
    // straps
    input  wire logic                   pci_host_strap,
    input  wire logic                   input_divide_strap,
    input  wire logic [RCW_W-1:0]       reset_config_word_low,
    // clock pins in
    input  wire logic                   primary_clock_in,
    input  wire logic                   pci_clock_in,
    input  wire logic                   pci_sync_in,
    // pci clock pins out
    output var  logic                   pci_sync_output,
    output var  logic [NUM_PCI_OUT-1:0] pci_clock_output_n,
    // memory and local bus clocks
    output var  logic                   memory_bus_clock_out,
    output var  logic                   memory_bus_clock_out_n,
    output var  logic                   ddr_data_en,
    output var  logic                   local_bus_sync_output,
    output var  logic [2:0]             local_bus_clock_outputs,
    // internal clock enables
    output var  logic                   csb_clk_en,
    output var  logic [NUM_UNITS-1:0]   unit_clk_en
);
    // captured straps and config word
    logic                   loaded_r;
    logic                   host_r;
    logic                   div_r;
    logic [3:0]             system_pll_multiplier_r;
    logic [3:0]             core_pll_multiplier_r;
    logic                   memory_clock_mode_r;
    logic                   local_bus_clock_mode_r;
    // software registers
    logic [NUM_PCI_OUT-1:0] occ_r;
    logic [1:0]             lbc_r;
    logic [14:0]            scc_r;
    logic [5:0]             ratio_r;
    logic                   sync_seen_r;
    // clock generation state
    logic                   prim_d_r;
    logic                   half_r;
    logic                   sync_d_r;
    logic                   pci_sync_out_r;
    logic [NUM_PCI_OUT-1:0] pci_clk_out_r;
    logic                   csb_en_r;
    logic                   mck_r;
    logic                   mck_n_r;
    logic                   ddr_data_en_r;
    logic [1:0]             lb_cnt_r;
    logic                   lb_clk_r;
    logic [2:0]             lb_outs_r;
    // bus
    logic                   ack_r;
    logic [31:0]            dat_r;

    // source select by strap
    wire prim_sel_w = host_r ? primary_clock_in
                             : pci_clock_in;
    wire prim_rise_w = prim_sel_w && !prim_d_r;
    wire sync_rise_w = pci_sync_in && !sync_d_r;

    // rate selects from the config word and the local bus divide register
    wire ddr_en_w  = memory_clock_mode_r  ? 1'b1 : csb_en_r;
    wire lbiu_en_w = local_bus_clock_mode_r ? 1'b1 : csb_en_r;
    wire [1:0] lb_last_w = (lbc_r == LBDIV_2) ? 2'h0 :
                           (lbc_r == LBDIV_4) ? 2'h1 : 2'h3;
    wire lb_wrap_w = lbiu_en_w && lb_cnt_r == lb_last_w;

    // system bus ratio, reserved code shows as zero ratio
    wire [4:0] mult_w = sccg_mult(system_pll_multiplier_r);
    wire [5:0] ratio_nxt = div_r ? {mult_w, 1'b0}
                                 : {1'b0, mult_w};

    // bus decode
    wire bus_req_w = wb_cyc_i && wb_stb_i;
    wire wr_fire_w = bus_req_w && wb_we_i && ack_r;
    wire wr_occ_w  = wr_fire_w && wb_adr_i == REG_OCC;
    wire wr_lbc_w  = wr_fire_w && wb_adr_i == REG_LBC;
    wire wr_scc_w  = wr_fire_w && wb_adr_i == REG_SCC;
    wire [31:0] rcw_v = {22'h0, local_bus_clock_mode_r, memory_clock_mode_r, core_pll_multiplier_r, system_pll_multiplier_r};
    wire [31:0] occ_v = {27'h0, occ_r};
    wire [31:0] lbc_v = {30'h0, lbc_r};
    wire [31:0] scc_v = {17'h0, scc_r};
    wire [31:0] st_v  = {20'h0, sync_seen_r, div_r, host_r,
                         system_pll_multiplier_r == SYSTEM_PLL_MULTIPLIER_RSVD, 2'h0, ratio_r};
    wire [31:0] rd_mux_w = (wb_adr_i == REG_RCW)    ? rcw_v :
                           (wb_adr_i == REG_OCC)    ? occ_v :
                           (wb_adr_i == REG_LBC)    ? lbc_v :
                           (wb_adr_i == REG_SCC)    ? scc_v :
                           (wb_adr_i == REG_STATUS) ? st_v  : 32'h0;
    wire [31:0] occ_m = sccg_merge(occ_v, wb_dat_i, wb_sel_i);
    wire [31:0] lbc_m = sccg_merge(lbc_v, wb_dat_i, wb_sel_i);
    wire [31:0] scc_m = sccg_merge(scc_v, wb_dat_i, wb_sel_i);

    // straps and config word caught one cycle after reset release
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            loaded_r  <= 1'b0;
            host_r    <= 1'b0;
            div_r     <= 1'b0;
            system_pll_multiplier_r    <= 4'h0;
            core_pll_multiplier_r <= 4'h0;
            memory_clock_mode_r   <= 1'b0;
            local_bus_clock_mode_r  <= 1'b0;
        end
        else if (!loaded_r)
        begin
            loaded_r  <= 1'b1;
            host_r    <= pci_host_strap;
            div_r     <= input_divide_strap;
            system_pll_multiplier_r    <= reset_config_word_low[RCW_SYSTEM_PLL_MULTIPLIER_LO +: 4];
            core_pll_multiplier_r <= reset_config_word_low[RCW_CORE_LO +: 4];
            memory_clock_mode_r   <= reset_config_word_low[RCW_MEMORY_CLOCK_MODE];
            local_bus_clock_mode_r  <= reset_config_word_low[RCW_LOCAL_BUS_CLOCK_MODE];
        end
    end

    // software registers; defaults hold until written
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            occ_r <= OCC_RST;
            lbc_r <= LBC_RST;
            scc_r <= SCC_RST;
        end
        else
        begin
            if (wr_occ_w)
                occ_r <= occ_m[NUM_PCI_OUT-1:0];
            if (wr_lbc_w)
                lbc_r <= lbc_m[1:0];
            if (wr_scc_w)
                scc_r <= scc_m[14:0];
        end
    end

    // status: ratio and whether the sync loop shows edges
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ratio_r     <= 6'h00;
            sync_d_r    <= 1'b0;
            sync_seen_r <= 1'b0;
        end
        else
        begin
            ratio_r  <= ratio_nxt;
            sync_d_r <= pci_sync_in;
            if (sync_rise_w && host_r)
                sync_seen_r <= 1'b1;
        end
    end

    // pci divider and output muxes; quiet in agent mode
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            prim_d_r       <= 1'b0;
            half_r         <= 1'b0;
            pci_sync_out_r <= 1'b0;
            pci_clk_out_r  <= '0;
        end
        else
        begin
            prim_d_r <= prim_sel_w;
            if (prim_rise_w)
                half_r <= !half_r;
            pci_sync_out_r <= host_r && (div_r ? half_r
                                               : prim_sel_w);
            for (int i = 0; i < NUM_PCI_OUT; i++)
                pci_clk_out_r[i] <= host_r && (occ_r[i] ? half_r
                                                        : prim_sel_w);
        end
    end

    // csb enable and memory clock pair; always out of phase
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            csb_en_r      <= 1'b0;
            mck_r         <= 1'b0;
            mck_n_r       <= 1'b1;
            ddr_data_en_r <= 1'b0;
        end
        else
        begin
            csb_en_r      <= loaded_r && !csb_en_r;
            ddr_data_en_r <= loaded_r && ddr_en_w;
            if (loaded_r && ddr_en_w)
            begin
                mck_r   <= !mck_r;
                mck_n_r <= mck_r;
            end
        end
    end

    // local bus divider; a new divide is compared at once, inside the current period
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            lb_cnt_r  <= 2'h0;
            lb_clk_r  <= 1'b0;
            lb_outs_r <= 3'h0;
        end
        else
        begin
            if (!loaded_r)
                lb_cnt_r <= 2'h0;
            else if (lb_wrap_w)
            begin
                lb_cnt_r <= 2'h0;
                lb_clk_r <= !lb_clk_r;
            end
            else if (lbiu_en_w)
                lb_cnt_r <= lb_cnt_r + 2'h1;
            lb_outs_r <= {3{lb_clk_r}};
        end
    end

    // unit clock enables: six ratio units, then PCI1, PCI2, DMA
    for (genvar u = 0; u < NUM_UNITS; u++)
    begin : g_unit
        localparam bit IS_RATIO = (u < NUM_RATIO);
        wire sccg_mode_t mode_w = IS_RATIO
            ? sccg_mode_t'(scc_r[2*u +: 2])
            : (scc_r[2*NUM_RATIO + u - NUM_RATIO] ? MODE_FULL
                                                  : MODE_OFF);
        sccg_ratio #(
            .RST_MODE (IS_RATIO ? MODE_THIRD : MODE_FULL)
        ) u_ratio (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .base_en  (csb_en_r),
            .mode_in  (mode_w),
            .unit_en  (unit_clk_en[u])
        );
    end

    // wishbone: ack one cycle after the request, dropped next cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end
        else
        begin
            ack_r <= bus_req_w && !ack_r;
            if (bus_req_w && !ack_r)
                dat_r <= rd_mux_w;                   // unmapped reads zero
        end
    end

    // outputs straight from flops
    assign wb_ack_o                = ack_r;
    assign wb_dat_o                = dat_r;
    assign pci_sync_output         = pci_sync_out_r;
    assign pci_clock_output_n      = pci_clk_out_r;
    assign memory_bus_clock_out    = mck_r;
    assign memory_bus_clock_out_n  = mck_n_r;
    assign ddr_data_en             = ddr_data_en_r;
    assign local_bus_sync_output   = lb_clk_r;
    assign local_bus_clock_outputs = lb_outs_r;
    assign csb_clk_en              = csb_en_r;

    AST_HOST_SOURCE: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        loaded_r && host_r && !occ_r[0] && $stable(occ_r)
        |=> pci_clk_out_r[0] == $past(primary_clock_in))
        else $error("host pci clock not from primary input");
    AST_AGENT_QUIET: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        loaded_r && !host_r |=> !pci_sync_out_r && pci_clk_out_r == '0)
        else $error("pci clock outputs driven in agent mode");
    AST_SYNC_HALF: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        loaded_r && host_r && div_r |=> pci_sync_out_r == $past(half_r))
        else $error("sync output not the halved clock");
    AST_MCK_PAIR: assert property (@(posedge core_clk)
        disable iff (sys_rst) mck_r != mck_n_r)
        else $error("memory clock pair not complementary");
    AST_DDR_RATE: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        loaded_r && memory_clock_mode_r ##1 loaded_r |-> ddr_data_en_r [*2])
        else $error("double memory rate not every cycle");
    AST_LB_DIV2: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (loaded_r && local_bus_clock_mode_r && lbc_r == LBDIV_2) [*3]
        |=> lb_clk_r != $past(lb_clk_r))
        else $error("local bus half rate not toggling");
    AST_RCW_HOLD: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        $past(loaded_r) |-> $stable(system_pll_multiplier_r) && $stable(core_pll_multiplier_r))
        else $error("config word changed after load");
    AST_X16_RATIO: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        loaded_r && system_pll_multiplier_r == SYSTEM_PLL_MULTIPLIER_X16 ##1 $stable(system_pll_multiplier_r)
        |-> ratio_r == (div_r ? 6'h20 : 6'h10))
        else $error("code zero not times sixteen");
    AST_SCC_DEFAULT: assert property (@(posedge core_clk)
        $past(sys_rst) |-> scc_r == SCC_RST)
        else $error("unit clock defaults wrong after reset");
    COV_HOST_HALF: cover property (@(posedge core_clk)
        host_r && div_r && $rose(pci_sync_out_r));
    COV_SCC_WRITE: cover property (@(posedge core_clk) wr_scc_w);
    COV_LB_DIV8: cover property (@(posedge core_clk)
        lbc_r == 2'h2 && lb_wrap_w);
endmodule
`default_nettype wire

/* File: tb/sccg_pci_agent_model.sv */
// sccg_pci_agent_model: board clock sources and the sync loop-back.
// assumes core_clk is the bench clock; levels move after its edge.
`timescale 1ns/1ps
`default_nettype none
module sccg_pci_agent_model
#(
    parameter int HALF = 3
)
(
    // clock
    input  wire logic core_clk,
    // mode and loop
    input  wire logic host_mode,
    input  wire logic pci_sync_output,
    // board clocks
    output wire logic primary_clock_in,
    output wire logic pci_clock_in,
    output var  logic pci_sync_in
);
    int   cnt_r = 0;
    logic ph_r  = 1'b0;
    initial pci_sync_in = 1'b0;
    // slow board clock, a level that flips every HALF cycles
    always @(posedge core_clk)
    begin
        cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
        if (cnt_r == HALF - 1)
            ph_r <= ~ph_r;
    end
    // agent boards ground the primary pin
    assign primary_clock_in = host_mode ? ph_r : 1'b0;
    assign pci_clock_in     = host_mode ? ~ph_r : ph_r;
    // loop-back with the delay that every agent sees
    always @(posedge core_clk)
        pci_sync_in <= pci_sync_output;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// tb_top: self-checking bench for the clock generation block.
// assumes the board model in sccg_pci_agent_model and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sccg_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic core_clk = 1'b0, sys_rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, pci_host_strap = 1'b1, input_divide_strap = 1'b0;
    logic [RCW_W-1:0] reset_config_word_low = 10'h000;
    wire logic primary_clock_in, pci_clock_in, pci_sync_in;
    logic pci_sync_output, memory_bus_clock_out, memory_bus_clock_out_n;
    logic ddr_data_en, local_bus_sync_output, csb_clk_en;
    logic [NUM_PCI_OUT-1:0] pci_clock_output_n;
    logic [2:0]             local_bus_clock_outputs;
    logic [NUM_UNITS-1:0]   unit_clk_en;
    int n_errors = 0, checks_done = 0;
    int hi[19], tg[19];
    // one probe vector so a single window counts every pin clock but the inverted memory clock and the local bus clock outputs
    wire logic [18:0] probe = {unit_clk_en, pci_clock_output_n,
        pci_sync_output, local_bus_sync_output, ddr_data_en,
        memory_bus_clock_out, csb_clk_en};

    always #5 core_clk = ~core_clk;

    sccg_top dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pci_host_strap(pci_host_strap),
        .input_divide_strap(input_divide_strap),
        .reset_config_word_low(reset_config_word_low),
        .primary_clock_in(primary_clock_in), .pci_clock_in(pci_clock_in),
        .pci_sync_in(pci_sync_in), .pci_sync_output(pci_sync_output),
        .pci_clock_output_n(pci_clock_output_n),
        .memory_bus_clock_out(memory_bus_clock_out),
        .memory_bus_clock_out_n(memory_bus_clock_out_n),
        .ddr_data_en(ddr_data_en),
        .local_bus_sync_output(local_bus_sync_output),
        .local_bus_clock_outputs(local_bus_clock_outputs),
        .csb_clk_en(csb_clk_en), .unit_clk_en(unit_clk_en));

    sccg_pci_agent_model board (.core_clk(core_clk),
        .host_mode(pci_host_strap), .pci_sync_output(pci_sync_output),
        .primary_clock_in(primary_clock_in), .pci_clock_in(pci_clock_in),
        .pci_sync_in(pci_sync_in));

    task automatic tally_and_finish();
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic single cycle; wait for ack under a bounded count
    task automatic wb_go(input logic we, input logic [7:0] adr,
        input logic [3:0] sel, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1)
        begin
            n_errors++;
            tally_and_finish();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [3:0] sel,
        input logic [31:0] d);
        logic [31:0] q;
        wb_go(1'b1, adr, sel, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp,
        input logic [31:0] msk);
        logic [31:0] q;
        wb_go(1'b0, adr, 4'hF, 32'h0000_0000, q);
        chk(q & msk, exp);
    endtask

    // 48 cycles: a whole number of periods of every pin clock
    task automatic measure();
        logic [18:0] prev;
        @(posedge core_clk);
        #1;
        prev = probe;
        for (int k = 0; k < 19; k++)
        begin
            hi[k] = 0;
            tg[k] = 0;
        end
        repeat (48)
        begin
            @(posedge core_clk);
            #1;
            for (int k = 0; k < 19; k++)
            begin
                hi[k] += (probe[k] === 1'b1);
                tg[k] += (probe[k] !== prev[k]);
            end
            prev = probe;
        end
    endtask

    // straps held across release; reset itself lasts 10 cycles
    task automatic t_config(input logic host, input logic div,
        input logic [9:0] cfg);
        logic [4:0]  m;
        logic [31:0] st;
        @(posedge core_clk);
        sys_rst <= 1'b1;
        pci_host_strap <= host;
        input_divide_strap <= div;
        reset_config_word_low <= cfg;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (16) @(posedge core_clk);
        m = (cfg[3:0] == 4'h0) ? 5'h10 :
            (cfg[3:0] == 4'h1) ? 5'h00 : {1'b0, cfg[3:0]};
        st = {20'h0, 1'b0, div, host, cfg[3:0] == 4'h1, 2'h0,
              6'(m * (div ? 2 : 1))};
        rd_chk(REG_STATUS, st, 32'h0000_07FF);
        wr(REG_RCW, 4'hF, ALL);
        rd_chk(REG_RCW, {22'h0, cfg}, ALL);
        wr(8'h14, 4'hF, ALL);
        rd_chk(8'h14, 32'h0000_0000, ALL);
        rd_chk(REG_OCC, 32'h0000_0000, ALL);
        rd_chk(REG_LBC, 32'h0000_0000, ALL);
        rd_chk(REG_SCC, 32'h0000_7FFF, ALL);
        measure();
        chk(tg[4], host ? (div ? 8 : 16) : 0);
        chk(tg[5], host ? 16 : 0);
        chk(hi[0], 24);
        chk(tg[1], cfg[8] ? 48 : 24);
        chk(hi[2], cfg[8] ? 48 : 24);
        chk(tg[3], cfg[9] ? 48 : 24);
    endtask

    task automatic t_defaults();
        measure();
        for (int k = 0; k < 6; k++)
            chk(hi[10+k], 8);
        for (int k = 6; k < 9; k++)
            chk(hi[10+k], 24);
    endtask

    // security stays third, usb at half or off
    task automatic t_unit_modes();
        int e[9] = '{0, 24, 12, 8, 0, 12, 0, 24, 0};
        wr(REG_SCC, 4'h3, 32'h0000_28E4);
        rd_chk(REG_SCC, 32'h0000_28E4, ALL);
        repeat (16) @(posedge core_clk);
        measure();
        for (int k = 0; k < 9; k++)
            chk(hi[10+k], e[k]);
        wr(REG_SCC, 4'h1, 32'h0000_FFFF);
        rd_chk(REG_SCC, 32'h0000_28FF, ALL);
    endtask

    task automatic t_pci_out();
        logic last;
        wr(REG_OCC, 4'hF, 32'h0000_0015);
        rd_chk(REG_OCC, 32'h0000_0015, ALL);
        repeat (16) @(posedge core_clk);
        measure();
        for (int k = 0; k < 5; k++)
            chk(tg[5+k], k[0] ? 16 : 8);
        last = primary_clock_in;
        repeat (12)
        begin
            @(posedge core_clk);
            #1;
            chk(pci_clock_output_n[1], last);
            last = primary_clock_in;
        end
    endtask

    // base runs every cycle here, so the divide codes are easy to tell
    task automatic t_lbus();
        int e[4] = '{48, 24, 12, 12};
        logic last;
        for (int c = 0; c < 4; c++)
        begin
            wr(REG_LBC, 4'hF, 32'(c));
            repeat (16) @(posedge core_clk);
            measure();
            chk(tg[3], e[c]);
        end
        last = local_bus_sync_output;
        repeat (8)
        begin
            @(posedge core_clk);
            #1;
            chk(local_bus_clock_outputs, {3{last}});
            last = local_bus_sync_output;
        end
    endtask

    initial
    begin
        t_config(1'b1, 1'b1, 10'h035);
        t_defaults();
        t_pci_out();
        t_unit_modes();
        t_config(1'b1, 1'b0, 10'h320);
        t_lbus();
        t_config(1'b0, 1'b0, 10'h011);
        tally_and_finish();
    end
endmodule
`default_nettype wire
